/* hw/misc_ctrl_regs.sv */
// Miscellaneous system control registers: interrupt sensitivity, clock
// prescaler and clock-out, peripheral power gating, halt policy, PWM pins.
// Assumes an AHB-Lite master on hclk and a core that reports its mask bits.
// Overview of operation
// (R1) Bits 7:6 reg one set port A sense
// (R2) Bits 4:3 reg one set port D sense
// (R3) Bits 3:2 reg three set port C sense
// (R4) Sense fields written only at level 3
// (R5) Sense write ignored unless both masks set
// (R6) Clock-out bit puts CPU clock on pin
// (R7) Prescaler off gives 3 or 6 MHz
// (R8) Stand-alone prescaler: 6, 1.5, 0.75, 0.375 MHz
// (R9) USB prescaler: 8, 2, 1, 0.25 MHz
// (R10) Stand-alone 6 MHz blocks USB buffer access
// (R11) USB slow clock: avoid buffer access
// (R12) Five gate bits switch peripherals off
// (R13) Gated peripherals keep register contents
// (R14) Reserved bits read zero
// (R15) Policy 0 plus watchdog: halt resets
// (R16) Policy 1: halt never resets
// (R17) USB suspend: halt never resets
// (R18) Bit 1 routes second PWM output
// (R19) Bit 0 routes first PWM output
// (R20) All registers reset to zero
// (R21) Watchdog activation is an input
`timescale 1ns/1ps

module misc_ctrl_regs
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic irq_mask_high,
  input wire logic irq_mask_low,
  input wire logic usb_mode,
  input wire logic usb_suspend,
  input wire logic watchdog_activation,
  input wire logic halt_request,
  output logic [1:0] port_a_irq_sense,
  output logic [1:0] port_d_irq_sense,
  output logic [1:0] port_c_irq_sense,
  output logic clock_out_select,
  output logic [7:0] cpu_clock_divide,
  output logic [2:0] cpu_clock_rate,
  output logic usb_buffer_block,
  output logic usb_buffer_caution,
  output logic [misc_ctrl_pkg::POWER_GATE_W-1:0] peripheral_off,
  output logic halt_enter,
  output logic halt_reset,
  output logic pwm_out_a_enable,
  output logic pwm_out_b_enable
);
  import misc_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] irq_sense_clock_ctrl_reg;
  logic [7:0] peripheral_power_gate_reg;
  logic [7:0] halt_pwm_irq_ctrl_reg;
  logic wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic halt_enter_reg;
  logic halt_reset_reg;
  logic [31:0] hrdata_reg;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Hsize is not checked: every register is one aligned word
  wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire rd_take = addr_phase && !hwrite;
  wire wr_take = addr_phase && hwrite;
  wire [ADDR_W-1:0] addr_lo = haddr[ADDR_W-1:0];
  wire mapped = (haddr[31:ADDR_W] == '0);
  wire [7:0] wdat = hwdata[7:0];
  // Sense fields are guarded: only writable at interrupt level 3
  wire level3 = irq_mask_high && irq_mask_low; // [R4] [R5]

  // ---------------------------------------------------------------
  // Field helpers
  // ---------------------------------------------------------------
  // One mask builder for the guarded sense fields; the other masks are fixed constants
  function automatic logic [7:0] field_mask(input int lsb, input int width);
    logic [7:0] m;
    m = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if (b >= lsb && b < lsb + width) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction

  // Address match shared by the write strobes and the read path
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // Bits a write may change; guarded sense bits drop out below level 3
  function automatic logic [7:0] write_mask(input logic [ADDR_W-1:0] a, input logic lvl);
    logic [7:0] m;
    m = 8'h00;
    if (reg_hit(a, IRQ_SENSE_CLOCK_CTRL_ADDR)) begin
      m = 8'hFF;
      if (!lvl) begin
        m = m & ~(field_mask(PORT_A_SENSE_LSB, 2) | field_mask(PORT_D_SENSE_LSB, 2));
      end
    end else if (reg_hit(a, PERIPHERAL_POWER_GATE_ADDR)) begin
      m = POWER_GATE_MASK;
    end else if (reg_hit(a, HALT_PWM_IRQ_CTRL_ADDR)) begin
      m = HALT_PWM_IRQ_MASK;
      if (!lvl) begin
        m = m & ~field_mask(PORT_C_SENSE_LSB, 2);
      end
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Every field and mask here assumes one byte per register
  if (POWER_GATE_W < 1 || POWER_GATE_W > 8) begin : g_bad_gate_width
    $error("Power gate field must fit in one byte");
  end
  if (PORT_A_SENSE_LSB > 6 || PORT_D_SENSE_LSB > 6 || PORT_C_SENSE_LSB > 6) begin : g_bad_sense_lsb
    $error("Sense fields must fit in one byte");
  end
  if (HALT_POLICY_BIT > 7 || CLOCK_OUT_SELECT_BIT > 7) begin : g_bad_bit_pos
    $error("Single-bit fields must fit in one byte");
  end
  if (ADDR_W < 10) begin : g_bad_addr_width
    $error("Address window too narrow for the register map");
  end
  if (IRQ_SENSE_CLOCK_CTRL_ADDR == PERIPHERAL_POWER_GATE_ADDR || IRQ_SENSE_CLOCK_CTRL_ADDR == HALT_PWM_IRQ_CTRL_ADDR)
  begin : g_bad_map
    $error("Register addresses must be distinct");
  end

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  // The data phase follows the address phase by one cycle
  wire wr_r1 = wr_pend_reg && reg_hit(wr_addr_reg, IRQ_SENSE_CLOCK_CTRL_ADDR);
  wire wr_r2 = wr_pend_reg && reg_hit(wr_addr_reg, PERIPHERAL_POWER_GATE_ADDR);
  wire wr_r3 = wr_pend_reg && reg_hit(wr_addr_reg, HALT_PWM_IRQ_CTRL_ADDR);
  wire [7:0] wr_mask = write_mask(wr_addr_reg, level3); // [R5]

  // Guarded bits keep their old value when the level check fails
  wire [7:0] r1_next = (wdat & wr_mask) | (irq_sense_clock_ctrl_reg & ~wr_mask); // [R1] [R2] [R6]
  wire [7:0] r2_next = ((wdat & wr_mask) | (peripheral_power_gate_reg & ~wr_mask)) & POWER_GATE_MASK; // [R12] [R14]
  wire [7:0] r3_next = ((wdat & wr_mask) | (halt_pwm_irq_ctrl_reg & ~wr_mask)) & HALT_PWM_IRQ_MASK; // [R3] [R14]

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // A read right behind a write to the same register sees the new byte
  wire [7:0] r1_view = wr_r1 ? r1_next : irq_sense_clock_ctrl_reg;
  wire [7:0] r2_view = wr_r2 ? r2_next : peripheral_power_gate_reg;
  wire [7:0] r3_view = wr_r3 ? r3_next : halt_pwm_irq_ctrl_reg;
  wire [7:0] rd_byte =
    reg_hit(addr_lo, IRQ_SENSE_CLOCK_CTRL_ADDR) ? r1_view :
    reg_hit(addr_lo, PERIPHERAL_POWER_GATE_ADDR) ? r2_view :
    reg_hit(addr_lo, HALT_PWM_IRQ_CTRL_ADDR) ? r3_view : 8'h00;
  // Unmapped addresses read zero and still answer OKAY
  wire [7:0] rd_lane = mapped ? rd_byte : 8'h00; // [R14]

  // ---------------------------------------------------------------
  // Bus state, zero wait states
  // ---------------------------------------------------------------
  // Only the address is kept; the byte itself arrives in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= wr_take && mapped;
      if (wr_take) begin
        wr_addr_reg <= addr_lo;
      end
    end
  end

  // Read data is captured at the address phase and stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= {24'h00_0000, rd_lane}; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Interrupt sense and clock register
  // ---------------------------------------------------------------
  // Sense bits and clock bits share one byte but not one guard
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sense_clock_ctrl_reg <= IRQ_SENSE_CLOCK_CTRL_RST; // [R20]
    end else if (wr_r1) begin
      irq_sense_clock_ctrl_reg <= r1_next;
    end
  end

  // ---------------------------------------------------------------
  // Power gate register
  // ---------------------------------------------------------------
  // Register contents are untouched by the power gates themselves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_power_gate_reg <= PERIPHERAL_POWER_GATE_RST; // [R20]
    end else if (wr_r2) begin
      peripheral_power_gate_reg <= r2_next;
    end
  end

  // ---------------------------------------------------------------
  // Halt and PWM register
  // ---------------------------------------------------------------
  // Reserved bits never reach the flops, so they cannot read back as one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_pwm_irq_ctrl_reg <= HALT_PWM_IRQ_CTRL_RST; // [R20]
    end else if (wr_r3) begin
      halt_pwm_irq_ctrl_reg <= r3_next;
    end
  end

  // ---------------------------------------------------------------
  // Bus response
  // ---------------------------------------------------------------
  assign hrdata = hrdata_reg;
  // No wait states and no error response: every access completes at once
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------
  // Field outputs
  // ---------------------------------------------------------------
  // Sense fields go straight to the edge detectors of each port group
  assign port_a_irq_sense = irq_sense_clock_ctrl_reg[PORT_A_SENSE_LSB +: 2]; // [R1]
  assign port_d_irq_sense = irq_sense_clock_ctrl_reg[PORT_D_SENSE_LSB +: 2]; // [R2]
  assign port_c_irq_sense = halt_pwm_irq_ctrl_reg[PORT_C_SENSE_LSB +: 2]; // [R3]
  assign clock_out_select = irq_sense_clock_ctrl_reg[CLOCK_OUT_SELECT_BIT]; // [R6]
  // Peripherals freeze their own state while off; nothing is cleared here
  for (genvar g = 0; g < POWER_GATE_W; g++) begin : g_gate
    // Each gate bit reaches its own peripheral unchanged
    assign peripheral_off[g] = peripheral_power_gate_reg[g]; // [R12] [R13]
  end
  assign pwm_out_b_enable = halt_pwm_irq_ctrl_reg[PWM_OUT_B_BIT]; // [R18]
  assign pwm_out_a_enable = halt_pwm_irq_ctrl_reg[PWM_OUT_A_BIT]; // [R19]

  // ---------------------------------------------------------------
  // CPU clock selection
  // ---------------------------------------------------------------
  wire divider_enable = irq_sense_clock_ctrl_reg[DIVIDER_ENABLE_BIT];
  wire [1:0] cpu_clock_divider = irq_sense_clock_ctrl_reg[CPU_CLOCK_DIVIDER_LSB +: 2];

  // Ratios are from the source oscillator, so each mode has its own set of ratios
  function automatic logic [7:0] pick_div(input logic usb, input logic en, input logic [1:0] cp);
    logic [7:0] d;
    d = usb ? DIV_USB_DEFAULT : DIV_SA_DEFAULT;
    if (en) begin
      unique case (cp)
        2'b00: d = usb ? DIV_USB_00 : DIV_SA_00;
        2'b10: d = usb ? DIV_USB_10 : DIV_SA_10;
        2'b01: d = usb ? DIV_USB_01 : DIV_SA_01;
        2'b11: d = usb ? DIV_USB_11 : DIV_SA_11;
      endcase
    end
    return d;
  endfunction

  assign cpu_clock_divide = pick_div(usb_mode, divider_enable, cpu_clock_divider); // [R7] [R8] [R9]

  // USB rates of 1 MHz and below share the 2 MHz code
  function automatic logic [2:0] pick_rate(input logic usb, input logic en, input logic [1:0] cp);
    cpu_clock_rate_t r;
    r = usb ? CLK_USB_6M : CLK_SA_3M; // [R7]
    if (en && usb) begin
      unique case (cp)
        2'b00: r = CLK_USB_8M; // [R9]
        2'b10: r = CLK_USB_2M;
        2'b01: r = CLK_USB_2M;
        2'b11: r = CLK_USB_2M;
      endcase
    end else if (en) begin
      unique case (cp)
        2'b00: r = CLK_SA_6M; // [R8]
        2'b10: r = CLK_SA_1M5;
        2'b01: r = CLK_SA_750K;
        2'b11: r = CLK_SA_375K;
      endcase
    end
    return r;
  endfunction

  assign cpu_clock_rate = pick_rate(usb_mode, divider_enable, cpu_clock_divider); // [R7] [R8] [R9]

  // ---------------------------------------------------------------
  // Buffer access flags
  // ---------------------------------------------------------------
  // Fastest stand-alone rate leaves no slot for core buffer access
  wire sa_fast = !usb_mode && divider_enable && cpu_clock_divider == 2'b00;
  // USB rates at 2 MHz and below: core buffer access risks an overrun
  wire usb_slow = usb_mode && divider_enable && cpu_clock_divider != 2'b00;
  assign usb_buffer_block = sa_fast; // [R10]
  assign usb_buffer_caution = usb_slow; // [R11]

  // ---------------------------------------------------------------
  // Halt policy
  // ---------------------------------------------------------------
  // Suspend overrides the policy bit: no reset from halt while suspended
  wire halt_policy_bit = halt_pwm_irq_ctrl_reg[HALT_POLICY_BIT];
  wire watchdog_armed = watchdog_activation; // [R21]
  wire policy_allows_reset = !halt_policy_bit; // [R15] [R16]
  wire halt_resets = watchdog_armed && policy_allows_reset && !usb_suspend; // [R17]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_enter_reg <= 1'b0;
      halt_reset_reg <= 1'b0;
    end else begin
      halt_enter_reg <= halt_request && !halt_resets; // [R16] [R17]
      halt_reset_reg <= halt_request && halt_resets; // [R15]
    end
  end

  assign halt_enter = halt_enter_reg;
  assign halt_reset = halt_reset_reg;

endmodule // misc_ctrl_regs

/* hw/misc_ctrl_pkg.sv */
// Constants for the miscellaneous system control register bank.
// Assumes a 32-bit AHB-Lite slave, one aligned word per register.
package misc_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IRQ_SENSE_CLOCK_CTRL_IDX = 8'h49;
  localparam logic [7:0] PERIPHERAL_POWER_GATE_IDX = 8'h4A;
  localparam logic [7:0] HALT_PWM_IRQ_CTRL_IDX = 8'h4C;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] IRQ_SENSE_CLOCK_CTRL_ADDR = {IRQ_SENSE_CLOCK_CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] PERIPHERAL_POWER_GATE_ADDR = {PERIPHERAL_POWER_GATE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] HALT_PWM_IRQ_CTRL_ADDR = {HALT_PWM_IRQ_CTRL_IDX, 2'b00};

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IRQ_SENSE_CLOCK_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPHERAL_POWER_GATE_RST = 8'h00;
  localparam logic [7:0] HALT_PWM_IRQ_CTRL_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PORT_A_SENSE_LSB = 6;
  localparam int CLOCK_OUT_SELECT_BIT = 5;
  localparam int PORT_D_SENSE_LSB = 3;
  localparam int CPU_CLOCK_DIVIDER_LSB = 1;
  localparam int DIVIDER_ENABLE_BIT = 0;
  localparam int POWER_GATE_W = 5;
  localparam logic [7:0] POWER_GATE_MASK = 8'h1F;
  localparam int HALT_POLICY_BIT = 7;
  localparam int PORT_C_SENSE_LSB = 2;
  localparam int PWM_OUT_B_BIT = 1;
  localparam int PWM_OUT_A_BIT = 0;
  localparam logic [7:0] HALT_PWM_IRQ_MASK = 8'h8F;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SENSE_FALL_LOW = 2'b00,
    SENSE_RISE = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_BOTH = 2'b11
  } irq_sense_t;

  typedef enum logic [2:0] {
    CLK_SA_3M = 3'b000,
    CLK_SA_6M = 3'b001,
    CLK_SA_1M5 = 3'b010,
    CLK_SA_750K = 3'b011,
    CLK_SA_375K = 3'b100,
    CLK_USB_6M = 3'b101,
    CLK_USB_8M = 3'b110,
    CLK_USB_2M = 3'b111
  } cpu_clock_rate_t;

  // Divide ratios from the source oscillator (12 MHz stand-alone, 48 MHz USB)
  localparam logic [7:0] DIV_SA_DEFAULT = 8'h04;
  localparam logic [7:0] DIV_SA_00 = 8'h02;
  localparam logic [7:0] DIV_SA_10 = 8'h08;
  localparam logic [7:0] DIV_SA_01 = 8'h10;
  localparam logic [7:0] DIV_SA_11 = 8'h20;
  localparam logic [7:0] DIV_USB_DEFAULT = 8'h08;
  localparam logic [7:0] DIV_USB_00 = 8'h06;
  localparam logic [7:0] DIV_USB_10 = 8'h18;
  localparam logic [7:0] DIV_USB_01 = 8'h30;
  localparam logic [7:0] DIV_USB_11 = 8'hC0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;

endpackage

/* testbench/misc_ctrl_regs_props.sv */
// Checker for the miscellaneous control register bank.
// Assumes one clock domain; sees only the top ports.
`timescale 1ns/1ps
module misc_ctrl_regs_props
  import misc_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic irq_mask_high,
  input wire logic irq_mask_low,
  input wire logic usb_mode,
  input wire logic usb_suspend,
  input wire logic watchdog_activation,
  input wire logic halt_request,
  input wire logic [1:0] port_a_irq_sense,
  input wire logic [1:0] port_d_irq_sense,
  input wire logic [1:0] port_c_irq_sense,
  input wire logic [7:0] cpu_clock_divide,
  input wire logic [2:0] cpu_clock_rate,
  input wire logic usb_buffer_block,
  input wire logic halt_enter,
  input wire logic halt_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------
  // Properties
  // ----------------
  // Guard is sampled on the write edge, so the change shows one cycle later
  a_sense_guard: assert property (
    $changed({port_a_irq_sense, port_d_irq_sense, port_c_irq_sense}) |-> $past(irq_mask_high && irq_mask_low))
    else $error("Sense field changed while masked");
  a_halt_suspend: assert property (
    halt_request && usb_suspend |=> halt_enter && !halt_reset) else $error("Reset on halt in suspend");
  a_halt_no_wdg: assert property (
    halt_request && !watchdog_activation |=> halt_enter) else $error("Halt without watchdog not entered");
  a_halt_one_kind: assert property (
    halt_request |=> $onehot({halt_enter, halt_reset})) else $error("Halt outcome not exactly one");
  a_halt_quiet: assert property (
    !halt_request |=> !halt_enter && !halt_reset) else $error("Halt outcome without request");
  a_block_decode: assert property (
    usb_buffer_block == (!usb_mode && cpu_clock_rate == CLK_SA_6M)) else $error("Buffer block wrong");
  a_default_ratio: assert property (
    cpu_clock_rate == CLK_SA_3M |-> cpu_clock_divide == DIV_SA_DEFAULT) else $error("Default ratio wrong");
  a_usb_ratio: assert property (
    usb_mode && cpu_clock_rate == CLK_USB_8M |-> cpu_clock_divide == DIV_USB_00) else $error("USB ratio wrong");
  a_upper_zero: assert property (
    hrdata[31:8] == 24'h0 && !hresp) else $error("Upper read bits or response wrong");
  c_halt_reset: cover property (halt_reset);
  c_block: cover property (usb_buffer_block);
  c_both: cover property (port_a_irq_sense == SENSE_BOTH);
endmodule // misc_ctrl_regs_props

bind misc_ctrl_regs misc_ctrl_regs_props props (.hclk, .hresetn, .hrdata, .hresp, .irq_mask_high, .irq_mask_low,
  .usb_mode, .usb_suspend, .watchdog_activation, .halt_request, .port_a_irq_sense, .port_d_irq_sense,
  .port_c_irq_sense, .cpu_clock_divide, .cpu_clock_rate, .usb_buffer_block, .halt_enter, .halt_reset);

/* testbench/core_model.sv */
// Core side model: interrupt mask level and halt instruction.
// Assumes the bench calls its tasks; changes follow a rising edge.
`timescale 1ns/1ps
module core_model (
  input wire logic hclk,
  output logic irq_mask_high,
  output logic irq_mask_low,
  output logic halt_request
);
  initial begin
    irq_mask_high = 1'b0;
    irq_mask_low = 1'b0;
    halt_request = 1'b0;
  end
  // Level 3 means both mask bits set
  task automatic set_level(input logic [1:0] lv);
    @(posedge hclk);
    {irq_mask_high, irq_mask_low} <= lv;
  endtask
  task automatic halt();
    @(posedge hclk);
    halt_request <= 1'b1;
    @(posedge hclk);
    halt_request <= 1'b0;
  endtask
endmodule // core_model

/* testbench/misc_system_control_regs_bench.sv */
// Self-checking bench for the miscellaneous control register bank.
// Assumes a zero-wait AHB-Lite slave and the core model beside it.
`timescale 1ns/1ps
module misc_system_control_regs_bench;
  import misc_ctrl_pkg::*;
  localparam int SA_KHZ [5] = '{3000, 6000, 750, 1500, 375};
  localparam int USB_KHZ [5] = '{6000, 8000, 1000, 2000, 250};
  localparam logic [2:0] SA_RATE [5] = '{CLK_SA_3M, CLK_SA_6M, CLK_SA_750K, CLK_SA_1M5, CLK_SA_375K};
  localparam logic [2:0] USB_RATE [5] = '{CLK_USB_6M, CLK_USB_8M, CLK_USB_2M, CLK_USB_2M, CLK_USB_2M};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, usb_mode = 1'b0;
  logic usb_suspend = 1'b0, watchdog_activation = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready, hreadyout, hresp, irq_mask_high, irq_mask_low, halt_request, clock_out_select;
  wire logic usb_buffer_block, usb_buffer_caution, halt_enter, halt_reset, pwm_out_a_enable, pwm_out_b_enable;
  wire logic [31:0] hrdata;
  wire logic [1:0] port_a_irq_sense, port_d_irq_sense, port_c_irq_sense;
  wire logic [7:0] cpu_clock_divide;
  wire logic [2:0] cpu_clock_rate;
  wire logic [4:0] peripheral_off;
  int n_errors = 0, tests_run = 0;
  assign hready = hreadyout;
  misc_ctrl_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .irq_mask_high, .irq_mask_low, .usb_mode, .usb_suspend, .watchdog_activation,
    .halt_request, .port_a_irq_sense, .port_d_irq_sense, .port_c_irq_sense, .clock_out_select,
    .cpu_clock_divide, .cpu_clock_rate, .usb_buffer_block, .usb_buffer_caution, .peripheral_off,
    .halt_enter, .halt_reset, .pwm_out_a_enable, .pwm_out_b_enable);
  core_model core (.hclk, .irq_mask_high, .irq_mask_low, .halt_request);
  always #5 hclk = ~hclk;
  // ----------------
  // Shared tasks
  // ----------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait: a slave that never answers ends the run as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata;
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(q, {24'h0, e});
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset();
    rd(IRQ_SENSE_CLOCK_CTRL_ADDR, IRQ_SENSE_CLOCK_CTRL_RST);
    rd(PERIPHERAL_POWER_GATE_ADDR, PERIPHERAL_POWER_GATE_RST);
    rd(HALT_PWM_IRQ_CTRL_ADDR, HALT_PWM_IRQ_CTRL_RST);
    check(cpu_clock_divide, DIV_SA_DEFAULT);
  endtask
  task automatic t_sense();
    core.set_level(2'b01);
    wr(IRQ_SENSE_CLOCK_CTRL_ADDR, 8'hFF);
    rd(IRQ_SENSE_CLOCK_CTRL_ADDR, 8'h27);
    core.set_level(2'b11);
    for (int c = 0; c < 4; c++) begin
      wr(IRQ_SENSE_CLOCK_CTRL_ADDR, {c[1:0], 1'b0, c[1:0], 3'b000});
      wr(HALT_PWM_IRQ_CTRL_ADDR, {4'h0, c[1:0], 2'b00});
      check({port_a_irq_sense, port_d_irq_sense, port_c_irq_sense}, {3{c[1:0]}});
    end
    core.set_level(2'b10);
    wr(IRQ_SENSE_CLOCK_CTRL_ADDR, 8'h00);
    wr(HALT_PWM_IRQ_CTRL_ADDR, 8'h00);
    check({port_a_irq_sense, port_d_irq_sense, port_c_irq_sense}, 6'h3F);
  endtask
  task automatic t_clock();
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 5; i++) begin
        usb_mode <= m[0];
        wr(IRQ_SENSE_CLOCK_CTRL_ADDR, (i == 0) ? 8'h20 : {5'h0, 2'(i - 1), 1'b1});
        check(clock_out_select, i == 0);
        check(cpu_clock_divide, (m ? 48000 / USB_KHZ[i] : 12000 / SA_KHZ[i]));
        check(usb_buffer_block, m == 0 && i == 1);
        check(cpu_clock_rate, m ? USB_RATE[i] : SA_RATE[i]);
        check(usb_buffer_caution, m == 1 && i > 0 && USB_KHZ[i] <= 2000);
      end
    end
  endtask
  task automatic t_gate();
    wr(PERIPHERAL_POWER_GATE_ADDR, 8'hFF);
    rd(PERIPHERAL_POWER_GATE_ADDR, 8'h1F);
    wr(PERIPHERAL_POWER_GATE_ADDR, 8'h0A);
    check(peripheral_off, 5'h0A);
    rd(IRQ_SENSE_CLOCK_CTRL_ADDR, 8'hDF);
    wr(HALT_PWM_IRQ_CTRL_ADDR, 8'h71);
    rd(HALT_PWM_IRQ_CTRL_ADDR, 8'h0D);
    wr(HALT_PWM_IRQ_CTRL_ADDR, 8'h02);
    check({pwm_out_b_enable, pwm_out_a_enable}, 2'b10);
    wr(10'h134, 8'hFF);
    rd(10'h134, 8'h00);
  endtask
  task automatic t_halt();
    for (int k = 0; k < 8; k++) begin
      wr(HALT_PWM_IRQ_CTRL_ADDR, {k[2], 7'h0});
      watchdog_activation <= k[1];
      usb_suspend <= k[0];
      core.halt();
      #1;
      check({halt_reset, halt_enter}, (k == 2) ? 2'b10 : 2'b01);
    end
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_sense();
    t_clock();
    t_gate();
    t_halt();
    complete_run();
  end
endmodule // misc_system_control_regs_bench
